/* File: rtl/emcs_pkg.sv */
package emcs_pkg;

  // Register indices on the host port
  localparam logic [3:0] IDX_CTL_TWO   = 4'h0;
  localparam logic [3:0] IDX_STATUS    = 4'h1;
  localparam logic [3:0] IDX_BUF_WIN   = 4'h2;
  localparam logic [3:0] IDX_RDPTR_LO  = 4'h3;
  localparam logic [3:0] IDX_RDPTR_HI  = 4'h4;
  localparam logic [3:0] IDX_WRPTR_LO  = 4'h5;
  localparam logic [3:0] IDX_WRPTR_HI  = 4'h6;
  localparam logic [3:0] IDX_TALLY     = 4'h7;
  localparam logic [3:0] IDX_MAC_ONE   = 4'h8;
  localparam logic [3:0] IDX_MAC_THREE = 4'h9;
  localparam logic [3:0] IDX_MAC_FOUR  = 4'hA;
  localparam logic [3:0] IDX_MAXLEN_LO = 4'hB;
  localparam logic [3:0] IDX_MAXLEN_HI = 4'hC;

  // ethernet_control_two fields
  localparam int B_STEP = 7;
  localparam int B_DROP = 6;
  localparam int B_ON   = 5;
  // ethernet_status fields
  localparam int B_FAULT = 6;
  localparam int B_LATE  = 4;
  localparam int B_RXACT = 2;
  localparam int B_ABORT = 1;
  localparam int B_READY = 0;
  // mac_control_one fields
  localparam int B_PSEND = 3;
  localparam int B_PHON  = 2;
  localparam int B_PASS  = 1;
  localparam int B_RXON  = 0;
  localparam logic [7:0] MAC_ONE_MASK = 8'h0F;
  // mac_control_three fields
  localparam int B_PAD_HI = 7;
  localparam int B_PAD_LO = 5;
  localparam int B_CRC    = 4;
  localparam int B_HDR    = 3;
  localparam int B_OVER   = 2;
  localparam int B_LCHK   = 1;
  localparam int B_FDX    = 0;
  // mac_control_four fields
  localparam int B_WAIT = 6;
  localparam int B_BPNB = 5;
  localparam int B_SKIP = 4;
  localparam logic [7:0] MAC_FOUR_MASK = 8'h70;

  // Reset values
  localparam logic [15:0] MAXLEN_RST = 16'h05EE;

  // Padding codes and targets
  localparam logic [2:0] PAD_64_A = 3'h7;
  localparam logic [2:0] PAD_64_B = 3'h3;
  localparam logic [2:0] PAD_60   = 3'h1;
  localparam logic [2:0] PAD_VLAN = 3'h5;
  localparam logic [6:0] PAD_LEN_NONE = 7'h00;
  localparam logic [6:0] PAD_LEN_60   = 7'h3C;
  localparam logic [6:0] PAD_LEN_64   = 7'h40;
  localparam logic [15:0] VLAN_TYPE   = 16'h8100;

  // Frame figures
  localparam logic [15:0] LATE_COL_BYTES = 16'h0040;
  localparam logic [15:0] LEN_TYPE_MAX   = 16'h05DC;
  localparam logic [2:0]  HDR_BYTES      = 3'h4;

  // Timing
  localparam int CLK_MHZ    = 200;
  localparam int STARTUP_NS = 1000000;
  localparam int DEFER_NS   = 200000;
  localparam int STARTUP_CYC_DEF = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int DEFER_CYC_DEF   = (DEFER_NS * CLK_MHZ + 999) / 1000;

  // Transmit deferral states
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_DEFER = 2'b01,
    TX_HOLD  = 2'b10
  } emcs_tx_state_t;

endpackage

/* File: rtl/emcs_buf_mem.sv */
`timescale 1ns/10ps
`default_nettype none

module emcs_buf_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clock,
  input  wire logic          ce,
  // Write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read side
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_r
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Registered read keeps the host read path a clean flop
  always_ff @(posedge clock) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      if (re) begin
        rdata_r <= mem[raddr];
      end
    end
  end

endmodule // emcs_buf_mem

`default_nettype wire

/* File: rtl/emcs_top.sv */
`timescale 1ns/10ps
`default_nettype none

module emcs_top
  import emcs_pkg::*;
#(
  parameter int AW          = 13,
  parameter int STARTUP_CYC = STARTUP_CYC_DEF,
  parameter int DEFER_CYC   = DEFER_CYC_DEF
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Host register port
  input  wire logic [3:0]  host_idx,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata_r,
  output logic             host_rvalid_r,
  // Receive side events
  input  wire logic        rx_in_frame,
  input  wire logic        rx_packet_stored,
  input  wire logic        rx_pause_active,
  input  wire logic        rx_ctrl_frame_end,
  input  wire logic [15:0] rx_byte_count,
  input  wire logic        rx_frame_end,
  input  wire logic [15:0] rx_len_field,
  input  wire logic [15:0] rx_payload_len,
  // Transmit side events
  input  wire logic        tx_pending,
  input  wire logic        tx_in_frame,
  input  wire logic [15:0] tx_byte_count,
  input  wire logic        tx_frame_end,
  input  wire logic [15:0] tx_len_field,
  input  wire logic [15:0] tx_payload_len,
  input  wire logic [15:0] tx_type_field,
  input  wire logic        tx_pause_req,
  input  wire logic        medium_busy,
  input  wire logic        tx_collision,
  input  wire logic        tx_backpressure_col,
  input  wire logic        tx_abort_event,
  input  wire logic        buf_error_event,
  // MAC control outputs
  output logic             rx_accept_r,
  output logic             tx_pause_inhibit_r,
  output logic             pause_tx_grant_r,
  output logic             ctrl_store_r,
  output logic             ctrl_discard_r,
  output logic      [6:0]  pad_target_r,
  output logic             crc_append_r,
  output logic             crc_check_r,
  output logic      [2:0]  crc_skip_r,
  output logic             full_duplex_r,
  output logic             tx_size_abort_r,
  output logic             rx_size_abort_r,
  output logic             tx_len_err_r,
  output logic             rx_len_err_r,
  output logic             defer_abort_r,
  output logic             retry_now_r,
  output logic             retry_backoff_r,
  output logic             phy_ready_r
);

  typedef struct packed {
    logic           step;
    logic           on;
    logic           fault;
    logic           late;
    logic           abort;
    logic           ready;
    logic           rx_act;
    logic [AW-1:0]  rd_ptr;
    logic [AW-1:0]  wr_ptr;
    logic [7:0]     tally;
    logic [7:0]     mac1;
    logic [7:0]     mac3;
    logic [7:0]     mac4;
    logic [15:0]    maxlen;
    logic [31:0]    st_cnt;
    logic [31:0]    df_cnt;
    emcs_tx_state_t tx_st;
    logic           last_mac;
    logic           rd_p1;
    logic           rd_win;
    logic [7:0]     snap;
    logic [7:0]     rdata;
    logic           rvalid;
    logic           rx_acc;
    logic           p_inh;
    logic           p_grant;
    logic           c_store;
    logic           c_drop;
    logic [6:0]     pad;
    logic           crc_app;
    logic           crc_chk;
    logic [2:0]     crc_skip;
    logic           fdx;
    logic           tx_big;
    logic           rx_big;
    logic           tx_lerr;
    logic           rx_lerr;
    logic           df_abort;
    logic           r_now;
    logic           r_back;
  } emcs_state_t;

  emcs_state_t s_r;
  emcs_state_t s_nxt;
  logic [7:0]  mem_rdata;
  logic        win_wr;
  logic        win_rd;

  localparam logic [AW-1:0] PTR_TOP = {AW{1'b1}};
  localparam logic [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
  localparam logic [31:0]   ST_LAST = 32'(STARTUP_CYC - 1);
  localparam logic [31:0]   DF_LAST = 32'(DEFER_CYC - 1);

  // Frame longer than the programmed limit while huge frames are barred
  function automatic logic too_long(input logic [15:0] cnt, input logic [15:0] lim,
                                    input logic allow);
    too_long = !allow && (cnt > lim);
  endfunction

  // Type/length field that holds a length and disagrees with the payload
  function automatic logic len_bad(input logic [15:0] fld, input logic [15:0] len);
    len_bad = (fld <= LEN_TYPE_MAX) && (fld != len);
  endfunction

  // Pad target for a given code and frame type
  function automatic logic [6:0] pad_len(input logic [2:0] code, input logic vlan);
    if (code == PAD_64_A || code == PAD_64_B) begin
      pad_len = PAD_LEN_64;
    end else if (code == PAD_60) begin
      pad_len = PAD_LEN_60;
    end else if (code == PAD_VLAN) begin
      pad_len = vlan ? PAD_LEN_64 : PAD_LEN_60;
    end else begin
      pad_len = PAD_LEN_NONE;
    end
  endfunction

  // Window strobes feed the buffer memory directly
  assign win_wr = host_wr && (host_idx == IDX_BUF_WIN);
  assign win_rd = host_rd && (host_idx == IDX_BUF_WIN);

  emcs_buf_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .clock   (clock),
    .ce      (ce),
    .we      (win_wr),
    .waddr   (s_r.wr_ptr),
    .wdata   (host_wdata),
    .re      (win_rd),
    .raddr   (s_r.rd_ptr),
    .rdata_r (mem_rdata)
  );

  // Next-state logic for the whole block
  always_comb begin
    logic mac_idx;
    logic mac_ok;
    logic half;
    logic [7:0] stat;
    logic [7:0] rd_val;
    logic [15:0] ptr_rd;
    logic [15:0] ptr_wr;
    mac_idx = (host_idx >= IDX_MAC_ONE) && (host_idx <= IDX_MAXLEN_HI);
    // A MAC access right after another is dropped, as is any MAC access while off
    mac_ok  = s_r.on && !s_r.last_mac;
    half    = !s_r.mac3[B_FDX];
    ptr_rd  = 16'(s_r.rd_ptr);
    ptr_wr  = 16'(s_r.wr_ptr);
    stat    = 8'h00;
    rd_val  = 8'h00;
    stat[B_FAULT] = s_r.fault;
    stat[B_LATE]  = s_r.late;
    stat[B_RXACT] = s_r.rx_act;
    stat[B_ABORT] = s_r.abort;
    stat[B_READY] = s_r.ready;
    s_nxt = s_r;

    // Host writes
    if (host_wr) begin
      unique case (host_idx)
        IDX_CTL_TWO: begin
          s_nxt.step = host_wdata[B_STEP];
          s_nxt.on   = host_wdata[B_ON];
        end
        IDX_STATUS: begin
          // Only zeros clear; ones are ignored
          s_nxt.fault = s_r.fault & host_wdata[B_FAULT];
          s_nxt.late  = s_r.late  & host_wdata[B_LATE];
          s_nxt.abort = s_r.abort & host_wdata[B_ABORT];
        end
        IDX_RDPTR_LO: s_nxt.rd_ptr = AW'({ptr_rd[15:8], host_wdata});
        IDX_RDPTR_HI: s_nxt.rd_ptr = AW'({host_wdata, ptr_rd[7:0]});
        IDX_WRPTR_LO: s_nxt.wr_ptr = AW'({ptr_wr[15:8], host_wdata});
        IDX_WRPTR_HI: s_nxt.wr_ptr = AW'({host_wdata, ptr_wr[7:0]});
        IDX_MAC_ONE:   if (mac_ok) s_nxt.mac1 = host_wdata & MAC_ONE_MASK;
        IDX_MAC_THREE: if (mac_ok) s_nxt.mac3 = host_wdata;
        IDX_MAC_FOUR:  if (mac_ok) s_nxt.mac4 = host_wdata & MAC_FOUR_MASK;
        IDX_MAXLEN_LO: if (mac_ok) s_nxt.maxlen[7:0] = host_wdata;
        IDX_MAXLEN_HI: if (mac_ok) s_nxt.maxlen[15:8] = host_wdata;
        default: ;
      endcase
    end

    // Window access steps its pointer; fault on a write wrap past the top or an empty read
    if (win_wr) begin
      if (s_r.step) begin
        s_nxt.wr_ptr = s_r.wr_ptr + PTR_ONE;
        if (s_r.wr_ptr == PTR_TOP) begin
          s_nxt.fault = 1'b1;
        end
      end
    end
    if (win_rd) begin
      if (s_r.step) begin
        s_nxt.rd_ptr = s_r.rd_ptr + PTR_ONE;
      end
      if (s_r.rd_ptr == s_r.wr_ptr) begin
        s_nxt.fault = 1'b1;
      end
    end

    // Tally: a stored packet and a drop in the same cycle cancel out
    if (host_wr && host_idx == IDX_CTL_TWO && host_wdata[B_DROP]) begin
      if (!rx_packet_stored && s_r.tally != 8'h00) begin
        s_nxt.tally = s_r.tally - 8'h01;
      end
    end else if (rx_packet_stored && s_r.tally != 8'hFF) begin
      s_nxt.tally = s_r.tally + 8'h01;
    end

    // Host reads: snapshot now, answer two edges later
    unique case (host_idx)
      IDX_CTL_TWO: begin
        rd_val[B_STEP] = s_r.step;
        rd_val[B_ON]   = s_r.on;
      end
      IDX_STATUS:    rd_val = stat;
      IDX_RDPTR_LO:  rd_val = ptr_rd[7:0];
      IDX_RDPTR_HI:  rd_val = ptr_rd[15:8];
      IDX_WRPTR_LO:  rd_val = ptr_wr[7:0];
      IDX_WRPTR_HI:  rd_val = ptr_wr[15:8];
      IDX_TALLY:     rd_val = s_r.tally;
      IDX_MAC_ONE:   rd_val = mac_ok ? s_r.mac1 : 8'h00;
      IDX_MAC_THREE: rd_val = mac_ok ? s_r.mac3 : 8'h00;
      IDX_MAC_FOUR:  rd_val = mac_ok ? s_r.mac4 : 8'h00;
      IDX_MAXLEN_LO: rd_val = mac_ok ? s_r.maxlen[7:0] : 8'h00;
      IDX_MAXLEN_HI: rd_val = mac_ok ? s_r.maxlen[15:8] : 8'h00;
      default:       rd_val = 8'h00;
    endcase
    s_nxt.rd_p1  = host_rd;
    s_nxt.rd_win = win_rd;
    s_nxt.snap   = rd_val;
    s_nxt.rvalid = s_r.rd_p1;
    if (s_r.rd_p1) begin
      s_nxt.rdata = s_r.rd_win ? mem_rdata : s_r.snap;
    end
    // Gap tracking covers refused accesses too, any cycle without a MAC access ends it
    s_nxt.last_mac = (host_wr || host_rd) && mac_idx;

    // Startup timer runs from reset, independent of the enable bit
    if (!s_r.ready) begin
      if (s_r.st_cnt == ST_LAST) begin
        s_nxt.ready = 1'b1;
      end else begin
        s_nxt.st_cnt = s_r.st_cnt + 32'h0000_0001;
      end
    end

    // Receive path
    s_nxt.rx_acc  = s_r.on && s_r.mac1[B_RXON];
    s_nxt.rx_act  = s_r.rx_acc && rx_in_frame;
    s_nxt.p_inh   = s_r.mac1[B_PHON] && rx_pause_active;
    s_nxt.c_store = rx_ctrl_frame_end && s_r.rx_acc && s_r.mac1[B_PASS];
    s_nxt.c_drop  = rx_ctrl_frame_end && s_r.rx_acc && !s_r.mac1[B_PASS];

    // Transmit configuration
    s_nxt.p_grant  = tx_pause_req && s_r.on && s_r.mac1[B_PSEND];
    s_nxt.pad      = pad_len(s_r.mac3[B_PAD_HI:B_PAD_LO], tx_type_field == VLAN_TYPE);
    s_nxt.crc_app  = s_r.mac3[B_CRC];
    s_nxt.crc_chk  = !s_r.mac3[B_CRC];
    s_nxt.crc_skip = s_r.mac3[B_HDR] ? HDR_BYTES : 3'h0;
    s_nxt.fdx      = s_r.mac3[B_FDX];

    // Size and length checks
    s_nxt.tx_big  = tx_in_frame && too_long(tx_byte_count, s_r.maxlen,
                                            s_r.mac3[B_OVER]);
    s_nxt.rx_big  = rx_in_frame && too_long(rx_byte_count, s_r.maxlen,
                                            s_r.mac3[B_OVER]);
    s_nxt.tx_lerr = tx_frame_end && s_r.mac3[B_LCHK]
                    && len_bad(tx_len_field, tx_payload_len);
    s_nxt.rx_lerr = rx_frame_end && s_r.mac3[B_LCHK]
                    && len_bad(rx_len_field, rx_payload_len);

    // Collisions: late detection and retry policy
    if (tx_collision && tx_byte_count >= LATE_COL_BYTES) begin
      s_nxt.late = 1'b1;
    end
    s_nxt.r_now  = half && ((tx_collision && s_r.mac4[B_SKIP])
                   || (tx_backpressure_col && s_r.mac4[B_BPNB]));
    s_nxt.r_back = half && ((tx_collision && !s_r.mac4[B_SKIP])
                   || (tx_backpressure_col && !s_r.mac4[B_BPNB]));

    // Deferral: count a busy medium while a transmit waits
    s_nxt.df_abort = 1'b0;
    unique case (s_r.tx_st)
      TX_IDLE: begin
        s_nxt.df_cnt = 32'h0000_0000;
        if (tx_pending && half && medium_busy) begin
          s_nxt.tx_st = TX_DEFER;
        end
      end
      TX_DEFER: begin
        if (!tx_pending || !medium_busy || !half) begin
          s_nxt.tx_st = TX_IDLE;
        end else if (s_r.mac4[B_WAIT]) begin
          s_nxt.df_cnt = 32'h0000_0000;
        end else if (s_r.df_cnt == DF_LAST) begin
          s_nxt.df_abort = 1'b1;
          s_nxt.tx_st    = TX_HOLD;
        end else begin
          s_nxt.df_cnt = s_r.df_cnt + 32'h0000_0001;
        end
      end
      TX_HOLD: begin
        // Wait for the aborted request to be withdrawn
        if (!tx_pending) begin
          s_nxt.tx_st = TX_IDLE;
        end
      end
      default: s_nxt.tx_st = TX_IDLE;
    endcase

    // Abort flag: set beats a same-cycle software clear
    if (tx_abort_event || s_nxt.df_abort) begin
      s_nxt.abort = 1'b1;
    end
    if (buf_error_event) begin
      s_nxt.fault = 1'b1;
    end

    // A disabled module drives no size aborts or retries
    if (!s_r.on) begin
      s_nxt.tx_big   = 1'b0;
      s_nxt.rx_big   = 1'b0;
      s_nxt.r_now    = 1'b0;
      s_nxt.r_back   = 1'b0;
    end
  end

  // State register with clock enable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r        <= '0;
      s_r.step   <= 1'b1;
      s_r.maxlen <= MAXLEN_RST;
      s_r.tx_st  <= TX_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state flops
  assign host_rdata_r       = s_r.rdata;
  assign host_rvalid_r      = s_r.rvalid;
  assign rx_accept_r        = s_r.rx_acc;
  assign tx_pause_inhibit_r = s_r.p_inh;
  assign pause_tx_grant_r   = s_r.p_grant;
  assign ctrl_store_r       = s_r.c_store;
  assign ctrl_discard_r     = s_r.c_drop;
  assign pad_target_r       = s_r.pad;
  assign crc_append_r       = s_r.crc_app;
  assign crc_check_r        = s_r.crc_chk;
  assign crc_skip_r         = s_r.crc_skip;
  assign full_duplex_r      = s_r.fdx;
  assign tx_size_abort_r    = s_r.tx_big;
  assign rx_size_abort_r    = s_r.rx_big;
  assign tx_len_err_r       = s_r.tx_lerr;
  assign rx_len_err_r       = s_r.rx_lerr;
  assign defer_abort_r      = s_r.df_abort;
  assign retry_now_r        = s_r.r_now;
  assign retry_backoff_r    = s_r.r_back;
  assign phy_ready_r        = s_r.ready;

endmodule // emcs_top

`default_nettype wire

/* File: bench/emcs_properties.sv */
`timescale 1ns/10ps
`default_nettype none

module emcs_properties (
  // Clock, reset and host port
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        host_rd,
  input wire logic        host_rvalid_r,
  // Event inputs
  input wire logic        rx_pause_active,
  input wire logic        tx_pause_req,
  input wire logic        rx_ctrl_frame_end,
  input wire logic        rx_frame_end,
  input wire logic [15:0] rx_len_field,
  input wire logic [15:0] rx_payload_len,
  input wire logic        tx_collision,
  input wire logic        tx_backpressure_col,
  // MAC control outputs
  input wire logic        tx_pause_inhibit_r,
  input wire logic        pause_tx_grant_r,
  input wire logic        ctrl_store_r,
  input wire logic        ctrl_discard_r,
  input wire logic        crc_append_r,
  input wire logic        crc_check_r,
  input wire logic        rx_len_err_r,
  input wire logic        retry_now_r,
  input wire logic        phy_ready_r
);
  // One clock domain; checks sleep while reset is held
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_read_answer: assert property (host_rd |-> ##2 host_rvalid_r)
    else $error("read not answered");
  a_answer_cause: assert property (host_rvalid_r |-> $past(host_rd, 2))
    else $error("answer without read");
  a_pause_inhibit: assert property (tx_pause_inhibit_r |-> $past(rx_pause_active))
    else $error("inhibit without pause");
  a_pause_grant: assert property (pause_tx_grant_r |-> $past(tx_pause_req))
    else $error("grant without request");
  a_ctrl_route: assert property ((ctrl_store_r || ctrl_discard_r) |->
    $past(rx_ctrl_frame_end) && !(ctrl_store_r && ctrl_discard_r)) else $error("ctrl route");
  // First edge after release still holds the reset image
  a_crc_pair: assert property ($past(rst_n) |-> crc_check_r != crc_append_r)
    else $error("crc modes clash");
  a_len_err: assert property (rx_len_err_r |-> $past(rx_frame_end) &&
    $past(rx_len_field) <= 16'h05DC && $past(rx_len_field) != $past(rx_payload_len))
    else $error("length error cause");
  a_retry_cause: assert property (retry_now_r |-> $past(tx_collision || tx_backpressure_col))
    else $error("retry without collision");
  a_ready_sticky: assert property (phy_ready_r |=> phy_ready_r)
    else $error("ready dropped");
endmodule // emcs_properties

bind emcs_top emcs_properties u_chk (.*);

`default_nettype wire

/* File: bench/emcs_phy_model.sv */
`timescale 1ns/10ps
`default_nettype none

module emcs_phy_model (
  // Commands from the bench
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic        ctl,
  input  wire logic        pause,
  input  wire logic [15:0] len,
  input  wire logic [15:0] lenf,
  // Receive side toward the MAC
  output logic             rx_in_frame,
  output logic [15:0]      rx_byte_count,
  output logic             rx_frame_end,
  output logic             rx_packet_stored,
  output logic             rx_ctrl_frame_end,
  output logic             rx_pause_active,
  output logic [15:0]      rx_len_field,
  output logic [15:0]      rx_payload_len
);
  logic [15:0] left = 16'h0000;
  logic        fin  = 1'b0;

  // A frame lasts len cycles; a new go is ignored mid-frame
  always @(posedge clock) begin
    fin <= (left == 16'h0001);
    if (go && left == 16'h0000) begin
      left <= len;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end

  // Frame info, with one end pulse per frame
  assign rx_in_frame       = (left != 16'h0000);
  assign rx_byte_count     = len - left;
  assign rx_frame_end      = fin;
  assign rx_packet_stored  = fin && !ctl;
  assign rx_ctrl_frame_end = fin && ctl;
  assign rx_pause_active   = pause;
  assign rx_len_field      = lenf;
  assign rx_payload_len    = len;
endmodule // emcs_phy_model

`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top import emcs_pkg::*; ;
  logic        clock = 1'b0, rst_n = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
  logic        go = 1'b0, ctl = 1'b0, pause = 1'b0, tx_pause_req = 1'b0;
  logic        tx_in_frame = 1'b0, tx_frame_end = 1'b0, medium_busy = 1'b0;
  logic        tx_pending = 1'b0, tx_backpressure_col = 1'b0;
  logic        tx_collision = 1'b0, tx_abort_event = 1'b0, buf_error_event = 1'b0;
  logic [3:0]  host_idx = 4'h0;
  logic [7:0]  host_wdata = 8'h00, host_rdata_r, v;
  logic [15:0] len = 16'h0008, lenf = 16'h0010, tx_byte_count = 16'h0000;
  logic [15:0] tx_type_field = 16'h8100, rx_byte_count, rx_len_field, rx_payload_len;
  logic        host_rvalid_r, rx_in_frame, rx_frame_end, rx_packet_stored;
  logic        rx_ctrl_frame_end, rx_pause_active, rx_accept_r, tx_pause_inhibit_r;
  logic        pause_tx_grant_r, crc_append_r, full_duplex_r, rx_size_abort_r;
  logic        retry_now_r, phy_ready_r, tx_size_abort_r, retry_backoff_r;
  logic [6:0]  pad_target_r, e;
  logic [2:0]  crc_skip_r, p;
  int          fail_count = 0, checks_done = 0;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  emcs_top #(.STARTUP_CYC(8), .DEFER_CYC(8)) dut (
    .*,
    .ce                  (1'b1),
    .tx_len_field        (16'h0000),
    .tx_payload_len      (16'h0000),
    .ctrl_store_r        (),
    .ctrl_discard_r      (),
    .crc_check_r         (),
    .tx_len_err_r        (),
    .rx_len_err_r        (),
    .defer_abort_r       ()
  );

  emcs_phy_model u_phy (.*);

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask

  // Strobe for one cycle, then idle one so MAC accesses never abut
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    @(negedge clock);
    host_idx = i;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clock);
    host_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] i, output logic [7:0] d);
    @(negedge clock);
    host_idx = i;
    host_rd = 1'b1;
    @(negedge clock);
    host_rd = 1'b0;
    for (int k = 0; k < 4 && host_rvalid_r !== 1'b1; k++)
      @(negedge clock);
    chk("rvalid", 16'h0001, {15'h0000, host_rvalid_r});
    d = host_rdata_r;
  endtask

  task automatic rc(input logic [3:0] i, input logic [7:0] x);
    logic [7:0] d;
    rd(i, d);
    chk($sformatf("reg %h", i), {8'h00, x}, {8'h00, d});
  endtask

  task automatic frame(input logic [15:0] l, input logic c);
    @(negedge clock);
    len = l;
    ctl = c;
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    test_done;
  end

  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    rc(IDX_STATUS, 8'h00);
    rc(IDX_CTL_TWO, 8'h80);
    wr(IDX_MAC_ONE, 8'h0F);
    rc(IDX_MAC_ONE, 8'h00);
    rc(IDX_STATUS, 8'h01);
    wr(IDX_CTL_TWO, 8'hA0);
    wr(IDX_WRPTR_LO, 8'h10);
    wr(IDX_RDPTR_LO, 8'h10);
    wr(IDX_BUF_WIN, 8'hA5);
    wr(IDX_BUF_WIN, 8'h3C);
    rc(IDX_BUF_WIN, 8'hA5);
    rc(IDX_BUF_WIN, 8'h3C);
    rd(IDX_BUF_WIN, v);
    rc(IDX_STATUS, 8'h41);
    wr(IDX_STATUS, 8'hFF);
    rc(IDX_STATUS, 8'h41);
    wr(IDX_STATUS, 8'h00);
    rc(IDX_STATUS, 8'h01);
    // Stepping off: pointers must stay put
    wr(IDX_CTL_TWO, 8'h20);
    wr(IDX_WRPTR_LO, 8'h20);
    wr(IDX_BUF_WIN, 8'h77);
    wr(IDX_BUF_WIN, 8'h66);
    wr(IDX_WRPTR_LO, 8'h21);
    wr(IDX_RDPTR_LO, 8'h20);
    rc(IDX_BUF_WIN, 8'h66);
    rc(IDX_BUF_WIN, 8'h66);
    wr(IDX_MAC_ONE, 8'h0D);
    rc(IDX_MAC_ONE, 8'h0D);
    chk("accept", 16'h0001, {15'h0000, rx_accept_r});
    tx_pause_req = 1'b1;
    pause = 1'b1;
    repeat (2) @(negedge clock);
    chk("grant", 16'h0001, {15'h0000, pause_tx_grant_r});
    chk("inhibit", 16'h0001, {15'h0000, tx_pause_inhibit_r});
    wr(IDX_MAC_ONE, 8'h01);
    @(negedge clock);
    chk("grant", 16'h0000, {15'h0000, pause_tx_grant_r});
    chk("inhibit", 16'h0000, {15'h0000, tx_pause_inhibit_r});
    // Every pad code, then the tagged code once more without the VLAN type
    for (int c = 0; c < 9; c++) begin
      p = (c == 8) ? 3'h5 : c[2:0];
      tx_type_field = (c == 8) ? 16'h0800 : 16'h8100;
      wr(IDX_MAC_THREE, {p, 5'h18});
      @(negedge clock);
      e = (p == 3'h7 || p == 3'h3) ? 7'h40 : (p == 3'h1) ? 7'h3C : 7'h00;
      if (p == 3'h5)
        e = (c == 8) ? 7'h3C : 7'h40;
      chk("pad", {9'h000, e}, {9'h000, pad_target_r});
    end
    chk("crc", 16'h0001, {15'h0000, crc_append_r});
    chk("skip", 16'h0004, {13'h0000, crc_skip_r});
    wr(IDX_MAC_THREE, 8'h19);
    @(negedge clock);
    chk("duplex", 16'h0001, {15'h0000, full_duplex_r});
    wr(IDX_MAC_THREE, 8'h1A);
    wr(IDX_MAXLEN_HI, 8'h00);
    wr(IDX_MAXLEN_LO, 8'h20);
    frame(16'h0028, 1'b0);
    rc(IDX_STATUS, 8'h05);
    repeat (32) @(negedge clock);
    chk("size", 16'h0001, {15'h0000, rx_size_abort_r});
    repeat (8) @(negedge clock);
    frame(16'h0008, 1'b1);
    repeat (12) @(negedge clock);
    frame(16'h0008, 1'b0);
    repeat (12) @(negedge clock);
    rc(IDX_TALLY, 8'h02);
    wr(IDX_CTL_TWO, 8'h60);
    rc(IDX_TALLY, 8'h01);
    rc(IDX_CTL_TWO, 8'h20);
    // Collisions either side of the 64 byte mark
    wr(IDX_MAC_FOUR, 8'h10);
    tx_in_frame = 1'b1;
    for (int b = 63; b < 65; b++) begin
      tx_byte_count = 16'(b);
      tx_collision = 1'b1;
      @(negedge clock);
      tx_collision = 1'b0;
      chk("retry", 16'h0001, {15'h0000, retry_now_r});
      chk("tx size", 16'h0001, {15'h0000, tx_size_abort_r});
      rc(IDX_STATUS, (b == 63) ? 8'h01 : 8'h11);
    end
    // Backpressure collision without its bypass bit must back off
    tx_backpressure_col = 1'b1;
    @(negedge clock);
    tx_backpressure_col = 1'b0;
    chk("backoff", 16'h0001, {15'h0000, retry_backoff_r});
    // Busy medium: waiting mode holds the request, otherwise the limit aborts it
    wr(IDX_MAC_FOUR, 8'h50);
    tx_pending = 1'b1;
    medium_busy = 1'b1;
    repeat (20) @(negedge clock);
    rc(IDX_STATUS, 8'h11);
    wr(IDX_MAC_FOUR, 8'h10);
    repeat (12) @(negedge clock);
    rc(IDX_STATUS, 8'h13);
    tx_pending = 1'b0;
    medium_busy = 1'b0;
    wr(IDX_STATUS, 8'hFD);
    tx_abort_event = 1'b1;
    buf_error_event = 1'b1;
    @(negedge clock);
    tx_abort_event = 1'b0;
    buf_error_event = 1'b0;
    rc(IDX_STATUS, 8'h53);
    wr(IDX_CTL_TWO, 8'h00);
    rc(IDX_MAC_ONE, 8'h00);
    test_done;
  end
endmodule // tb_top

`default_nettype wire
